// >>> pkg/tune_ctrl_pkg.sv
// constants, register map and state encoding of the calibration sequencer
// assumes a 200 MHz mclk and an AXI4-Lite register port with 32-bit data
package tune_ctrl_pkg;

	// ----------------------------------------
	// register map: printed index, byte address is four times it
	// ----------------------------------------
	localparam int ADDR_W = 8;
	localparam logic [5:0] IDX_TRIM = 6'h01;
	localparam logic [5:0] IDX_CTRL = 6'h02;
	localparam logic [5:0] IDX_STATUS = 6'h03;
	localparam logic [5:0] IDX_FSADJ = 6'h04;

	// ----------------------------------------
	// field positions and reset values
	// ----------------------------------------
	localparam int TRIM_INHIBIT_BIT = 13;
	localparam int CTRL_EXT_BIT = 0;
	localparam int CTRL_DCLK2_BIT = 1;
	localparam logic [15:0] TRIM_RESET = 16'h0000;
	localparam logic [1:0] CTRL_RESET = 2'h0;
	localparam logic [7:0] FSADJ_RESET = 8'h80;
	localparam logic [7:0] FS_CODE_HIGH = 8'hff;
	localparam logic [7:0] FS_CODE_LOW = 8'h00;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// ----------------------------------------
	// counts, in sample clock cycles unless noted
	// ----------------------------------------
	localparam int CAL_LOW_CYCLES = 1024;
	localparam int CAL_HIGH_CYCLES = 1024;
	localparam int CAL_RUN_CYCLES = 2048;
	localparam int SHORT_DELAY_CYCLES = 16384;
	localparam int LONG_DELAY_CYCLES = 262144;
	localparam int CNT_W = 20;
	// mclk cycles for the pin synchronisers to fill after reset
	localparam int SYNC_SETTLE_CYCLES = 3;
	// sample clock counted as stopped after this long without an edge
	localparam int MCLK_PERIOD_NS = 5;
	localparam int STALL_TIME_NS = 200;
	localparam int STALL_CYCLES = (STALL_TIME_NS + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS;

	// ----------------------------------------
	// sequencer states, gray along startup-delay-cal-idle
	// ----------------------------------------
	typedef enum logic [1:0] {
		ST_STARTUP = 2'b00,
		ST_DELAY = 2'b01,
		ST_CAL = 2'b11,
		ST_IDLE = 2'b10
	} tune_state_e;

endpackage

// >>> rtl/cal_request_qualifier.sv
// qualifier of the calibrate request pin: low run, then high run, then one pulse
// assumes req_level is already synchronised and sample_tick marks sample clock edges
`timescale 1ns/10ps
`default_nettype none
module cal_request_qualifier
	import tune_ctrl_pkg::*;
#(
	parameter int LOW_CYCLES = CAL_LOW_CYCLES,
	parameter int HIGH_CYCLES = CAL_HIGH_CYCLES
) (
	// clock and reset
	input wire logic mclk,
	input wire logic rst_n,
	// request pin and timing
	input wire logic sample_tick,
	input wire logic req_level,
	input wire logic enable,
	// qualified request
	output logic fire
);

	logic [CNT_W-1:0] low_cnt_reg;
	logic [CNT_W-1:0] high_cnt_reg;
	logic armed_reg;
	logic fire_reg;
	wire low_done = low_cnt_reg == CNT_W'(LOW_CYCLES - 1);
	wire high_done = high_cnt_reg == CNT_W'(HIGH_CYCLES - 1);

	assign fire = fire_reg;

	always_ff @(posedge mclk) begin
		if (!rst_n || !enable) begin
			low_cnt_reg <= '0;
			high_cnt_reg <= '0;
			armed_reg <= 1'b0;
			fire_reg <= 1'b0;
		end else begin
			fire_reg <= 1'b0;
			if (sample_tick && !req_level) begin
				high_cnt_reg <= '0;
				if (!armed_reg && low_done) begin
					armed_reg <= 1'b1;
				end else if (!armed_reg) begin
					low_cnt_reg <= low_cnt_reg + 1'b1;
				end
			end else if (sample_tick) begin
				low_cnt_reg <= '0;
				if (armed_reg && high_done) begin
					fire_reg <= 1'b1;
					armed_reg <= 1'b0;
					high_cnt_reg <= '0;
				end else if (armed_reg) begin
					high_cnt_reg <= high_cnt_reg + 1'b1;
				end
			end
		end
	end

	// ----------------------------------------
	// checks
	// ----------------------------------------
	AST_FIRE_AFTER_HIGH_RUN: assert property (@(posedge mclk) disable iff (!rst_n)
		fire_reg |-> $past(armed_reg) && $past(req_level)
			&& $past(high_cnt_reg) == CNT_W'(HIGH_CYCLES - 1))
		else $error("calibrate pulse without full high run");
	AST_NO_FIRE_DISABLED: assert property (@(posedge mclk) disable iff (!rst_n)
		!enable |=> !fire_reg)
		else $error("calibrate pulse while disabled");
	COV_FIRE: cover property (@(posedge mclk) disable iff (!rst_n) $rose(fire_reg));

endmodule
`default_nettype wire

// >>> rtl/tune_sequencer_top.sv
// Summary of operation
// - busy flag high exactly during calibration
// - stop data clocks during trimming calibration
// - power-up calibration only after delay interval
// - request high at power-up skips calibration
// - request qualified by low run then high run
// - termination trim at power-up, on command unless inhibit bit set
// - delay select pin picks delay length
// - power-down holds delay counter still
// - extended mode forces short delay
// - edge select high: launch on rising
// - edge select low: launch on falling
// - out-of-range pair may carry second clock
// - range from pin, or register in extended
// - swing pin selects driver strength
// - analog held down while sample clock stopped
// - power-down waits for running calibration
// - calibrate request ignored while powered down
// control-pin logic of a dual converter; registers over AXI4-Lite
// assumes pins and sample_clk are asynchronous to mclk; out_of_range_in is mclk logic
`timescale 1ns/10ps
`default_nettype none
module tune_sequencer_top
	import tune_ctrl_pkg::*;
#(
	parameter int SHORT_DELAY = SHORT_DELAY_CYCLES,
	parameter int LONG_DELAY = LONG_DELAY_CYCLES,
	parameter int CAL_RUN = CAL_RUN_CYCLES,
	parameter int CAL_LOW = CAL_LOW_CYCLES,
	parameter int CAL_HIGH = CAL_HIGH_CYCLES
) (
	// clock and reset
	input wire logic mclk,
	input wire logic rst_n,
	// converter sample clock
	input wire logic sample_clk,
	// control pins
	input wire logic cal_request,
	input wire logic tune_delay_select,
	input wire logic power_down_input,
	input wire logic launch_edge_select,
	input wire logic driver_swing_select,
	input wire logic input_range_select,
	// converter status
	input wire logic out_of_range_in,
	// control outputs
	output logic tune_in_progress,
	output logic data_output_clock,
	output logic second_pair_out,
	output logic data_launch,
	output logic driver_strong,
	output logic term_trim_active,
	output logic analog_power_down,
	output logic range_from_register,
	output logic [7:0] full_scale_code,
	// axi4-lite write
	input wire logic [ADDR_W-1:0] s_axi_awaddr,
	input wire logic [2:0] s_axi_awprot,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// axi4-lite read
	input wire logic [ADDR_W-1:0] s_axi_araddr,
	input wire logic [2:0] s_axi_arprot,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready
);

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
		is_mapped = a[1:0] == 2'b00 && (a[7:2] == IDX_TRIM || a[7:2] == IDX_CTRL
			|| a[7:2] == IDX_STATUS || a[7:2] == IDX_FSADJ);
	endfunction

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] strb);
		for (int i = 0; i < 4; i++) begin
			merge[8*i +: 8] = strb[i] ? nw[8*i +: 8] : old[8*i +: 8];
		end
	endfunction

	// ----------------------------------------
	// synchronisers
	// ----------------------------------------
	logic [5:0] pin_meta_reg;
	logic [5:0] pin_sync_reg;
	logic sclk_meta_reg;
	logic sclk_sync_reg;
	logic sclk_last_reg;

	wire cal_sync = pin_sync_reg[0];
	wire dly_sync = pin_sync_reg[1];
	wire pd_sync = pin_sync_reg[2];
	wire edge_sync = pin_sync_reg[3];
	wire swing_sync = pin_sync_reg[4];
	wire range_sync = pin_sync_reg[5];
	wire sample_tick = sclk_sync_reg && !sclk_last_reg;

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			pin_meta_reg <= '0;
			pin_sync_reg <= '0;
			sclk_meta_reg <= 1'b0;
			sclk_sync_reg <= 1'b0;
			sclk_last_reg <= 1'b0;
		end else begin
			pin_meta_reg <= {input_range_select, driver_swing_select, launch_edge_select,
				power_down_input, tune_delay_select, cal_request};
			pin_sync_reg <= pin_meta_reg;
			sclk_meta_reg <= sample_clk;
			sclk_sync_reg <= sclk_meta_reg;
			sclk_last_reg <= sclk_sync_reg;
		end
	end

	// ----------------------------------------
	// registers and state
	// ----------------------------------------
	logic [15:0] trim_reg;
	logic [1:0] ctrl_reg;
	logic [7:0] fsadj_reg;
	tune_state_e state_reg;
	tune_state_e state_next;
	logic [CNT_W-1:0] cnt_reg;
	logic [CNT_W-1:0] cnt_next;
	logic trim_cal_reg;
	logic trim_cal_next;
	logic calibrated_reg;
	logic calibrated_next;
	logic [7:0] stall_reg;
	logic pd_reg;
	logic cal_fire;

	wire ext_mode = ctrl_reg[CTRL_EXT_BIT];
	wire clk_alive = stall_reg < 8'(STALL_CYCLES);
	wire [CNT_W-1:0] delay_last = (ext_mode || !dly_sync) ? CNT_W'(SHORT_DELAY - 1)
		: CNT_W'(LONG_DELAY - 1);
	wire [CNT_W-1:0] run_last = CNT_W'(CAL_RUN - 1);

	cal_request_qualifier #(
		.LOW_CYCLES(CAL_LOW),
		.HIGH_CYCLES(CAL_HIGH)
	) u_qual (
		.mclk(mclk),
		.rst_n(rst_n),
		.sample_tick(sample_tick),
		.req_level(cal_sync),
		.enable(!pd_sync),
		.fire(cal_fire)
	);

	// ----------------------------------------
	// calibration sequencer
	// ----------------------------------------
	always_comb begin
		state_next = state_reg;
		cnt_next = cnt_reg;
		trim_cal_next = trim_cal_reg;
		calibrated_next = calibrated_reg;
		case (state_reg)
			ST_STARTUP: begin
				cnt_next = cnt_reg + 1'b1;
				if (cnt_reg == CNT_W'(SYNC_SETTLE_CYCLES)) begin
					cnt_next = '0;
					state_next = cal_sync ? ST_IDLE : ST_DELAY;
				end
			end
			ST_DELAY: begin
				if (!pd_sync && sample_tick && cnt_reg >= delay_last) begin
					cnt_next = '0;
					trim_cal_next = 1'b1;
					state_next = ST_CAL;
				end else if (!pd_sync && sample_tick) begin
					cnt_next = cnt_reg + 1'b1;
				end
			end
			ST_CAL: begin
				if (sample_tick && cnt_reg == run_last) begin
					cnt_next = '0;
					calibrated_next = 1'b1;
					state_next = ST_IDLE;
				end else if (sample_tick) begin
					cnt_next = cnt_reg + 1'b1;
				end
			end
			ST_IDLE: begin
				if (cal_fire) begin
					trim_cal_next = !trim_reg[TRIM_INHIBIT_BIT];
					state_next = ST_CAL;
				end
			end
			default: begin
				state_next = ST_STARTUP;
			end
		endcase
	end

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			state_reg <= ST_STARTUP;
			cnt_reg <= '0;
			trim_cal_reg <= 1'b0;
			calibrated_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			cnt_reg <= cnt_next;
			trim_cal_reg <= trim_cal_next;
			calibrated_reg <= calibrated_next;
		end
	end

	// ----------------------------------------
	// pin-facing outputs
	// ----------------------------------------
	logic tune_reg;
	logic data_output_clock_reg;
	logic dclk2_reg;
	logic launch_reg;
	logic strong_reg;
	logic trim_act_reg;
	logic apd_reg;
	logic range_reg_sel_reg;
	logic [7:0] fs_code_reg;

	wire cal_next = state_next == ST_CAL;
	wire data_output_clock_run = !(cal_next && trim_cal_next);
	wire data_output_clock_next = (data_output_clock_run && sample_tick) ? !data_output_clock_reg : data_output_clock_reg;
	wire launch_next = data_output_clock_run && sample_tick && data_output_clock_next == edge_sync;
	wire pd_next = pd_sync && !cal_next;
	wire [7:0] stall_next = sample_tick ? 8'h00
		: (clk_alive ? stall_reg + 8'h01 : stall_reg);
	wire [7:0] fs_code_next = ext_mode ? fsadj_reg
		: (range_sync ? FS_CODE_HIGH : FS_CODE_LOW);

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			tune_reg <= 1'b0;
			data_output_clock_reg <= 1'b0;
			dclk2_reg <= 1'b0;
			launch_reg <= 1'b0;
			strong_reg <= 1'b0;
			trim_act_reg <= 1'b0;
			apd_reg <= 1'b1;
			pd_reg <= 1'b0;
			stall_reg <= 8'(STALL_CYCLES);
			range_reg_sel_reg <= 1'b0;
			fs_code_reg <= FS_CODE_LOW;
		end else begin
			tune_reg <= cal_next;
			data_output_clock_reg <= data_output_clock_next;
			dclk2_reg <= ctrl_reg[CTRL_DCLK2_BIT] ? data_output_clock_next : out_of_range_in;
			launch_reg <= launch_next;
			strong_reg <= swing_sync;
			trim_act_reg <= cal_next && trim_cal_next;
			apd_reg <= pd_next || !clk_alive;
			pd_reg <= pd_next;
			stall_reg <= stall_next;
			range_reg_sel_reg <= ext_mode;
			fs_code_reg <= fs_code_next;
		end
	end

	assign tune_in_progress = tune_reg;
	assign data_output_clock = data_output_clock_reg;
	assign second_pair_out = dclk2_reg;
	assign data_launch = launch_reg;
	assign driver_strong = strong_reg;
	assign term_trim_active = trim_act_reg;
	assign analog_power_down = apd_reg;
	assign range_from_register = range_reg_sel_reg;
	assign full_scale_code = fs_code_reg;

	// ----------------------------------------
	// axi4-lite slave, one write and one read at a time
	// ----------------------------------------
	logic awready_reg;
	logic wready_reg;
	logic bvalid_reg;
	logic [1:0] bresp_reg;
	logic aw_hold_reg;
	logic w_hold_reg;
	logic [ADDR_W-1:0] aw_addr_reg;
	logic [31:0] w_data_reg;
	logic [3:0] w_strb_reg;
	logic arready_reg;
	logic rvalid_reg;
	logic [31:0] rdata_reg;
	logic [1:0] rresp_reg;

	wire aw_take = s_axi_awvalid && awready_reg;
	wire w_take = s_axi_wvalid && wready_reg;
	wire wr_do = (aw_hold_reg || aw_take) && (w_hold_reg || w_take) && !bvalid_reg;
	wire [ADDR_W-1:0] wr_addr = aw_take ? s_axi_awaddr : aw_addr_reg;
	wire [31:0] wr_data = w_take ? s_axi_wdata : w_data_reg;
	wire [3:0] wr_strb = w_take ? s_axi_wstrb : w_strb_reg;
	wire [5:0] wr_idx = wr_addr[7:2];
	wire wr_ok = is_mapped(wr_addr);
	wire bvalid_next = wr_do || (bvalid_reg && !s_axi_bready);
	wire aw_hold_next = !wr_do && (aw_hold_reg || aw_take);
	wire w_hold_next = !wr_do && (w_hold_reg || w_take);
	wire [31:0] wr_merged_trim = merge({16'h0000, trim_reg}, wr_data, wr_strb);
	wire [31:0] wr_merged_ctrl = merge({30'h0, ctrl_reg}, wr_data, wr_strb);
	wire [31:0] wr_merged_fs = merge({24'h0, fsadj_reg}, wr_data, wr_strb);
	wire trim_we = wr_do && wr_ok && wr_idx == IDX_TRIM && ext_mode;
	wire ctrl_we = wr_do && wr_ok && wr_idx == IDX_CTRL;
	wire fs_we = wr_do && wr_ok && wr_idx == IDX_FSADJ;

	wire ar_take = s_axi_arvalid && arready_reg;
	wire [5:0] rd_idx = s_axi_araddr[7:2];
	wire [31:0] status_word = {26'h0, state_reg, clk_alive, pd_reg, calibrated_reg, tune_reg};
	wire [31:0] rd_word = !is_mapped(s_axi_araddr) ? 32'h0
		: rd_idx == IDX_TRIM ? {16'h0000, trim_reg}
		: rd_idx == IDX_CTRL ? {30'h0, ctrl_reg}
		: rd_idx == IDX_STATUS ? status_word
		: {24'h0, fsadj_reg};
	wire rvalid_next = ar_take || (rvalid_reg && !s_axi_rready);

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			trim_reg <= TRIM_RESET;
			ctrl_reg <= CTRL_RESET;
			fsadj_reg <= FSADJ_RESET;
			awready_reg <= 1'b0;
			wready_reg <= 1'b0;
			bvalid_reg <= 1'b0;
			bresp_reg <= RESP_OKAY;
			aw_hold_reg <= 1'b0;
			w_hold_reg <= 1'b0;
			aw_addr_reg <= '0;
			w_data_reg <= 32'h0;
			w_strb_reg <= 4'h0;
			arready_reg <= 1'b0;
			rvalid_reg <= 1'b0;
			rdata_reg <= 32'h0;
			rresp_reg <= RESP_OKAY;
		end else begin
			if (trim_we) trim_reg <= wr_merged_trim[15:0];
			if (ctrl_we) ctrl_reg <= wr_merged_ctrl[1:0];
			if (fs_we) fsadj_reg <= wr_merged_fs[7:0];
			if (aw_take) aw_addr_reg <= s_axi_awaddr;
			if (w_take) w_data_reg <= s_axi_wdata;
			if (w_take) w_strb_reg <= s_axi_wstrb;
			if (wr_do) bresp_reg <= wr_ok ? RESP_OKAY : RESP_SLVERR;
			aw_hold_reg <= aw_hold_next;
			w_hold_reg <= w_hold_next;
			bvalid_reg <= bvalid_next;
			awready_reg <= !aw_hold_next && !bvalid_next;
			wready_reg <= !w_hold_next && !bvalid_next;
			if (ar_take) rdata_reg <= rd_word;
			if (ar_take) rresp_reg <= is_mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
			rvalid_reg <= rvalid_next;
			arready_reg <= !rvalid_next;
		end
	end

	assign s_axi_awready = awready_reg;
	assign s_axi_wready = wready_reg;
	assign s_axi_bvalid = bvalid_reg;
	assign s_axi_bresp = bresp_reg;
	assign s_axi_arready = arready_reg;
	assign s_axi_rvalid = rvalid_reg;
	assign s_axi_rdata = rdata_reg;
	assign s_axi_rresp = rresp_reg;

	// ----------------------------------------
	// checks
	// ----------------------------------------
	default clocking dflt @(posedge mclk); endclocking
	default disable iff (!rst_n);

	AST_BUSY_MATCHES_CAL: assert property (
		tune_in_progress == (state_reg == ST_CAL))
		else $error("busy flag disagrees with calibration state");
	AST_DATA_OUTPUT_CLOCK_FROZEN_IN_TRIM: assert property (
		(state_reg == ST_CAL && trim_cal_reg) [*2] |-> $stable(data_output_clock))
		else $error("data clock toggled during trimming calibration");
	AST_DELAY_FROZEN_IN_PD: assert property (
		(state_reg == ST_DELAY && pd_sync) |=> $stable(cnt_reg))
		else $error("delay counter moved while powered down");
	AST_SHORT_IN_EXT: assert property (
		ext_mode |-> delay_last == CNT_W'(SHORT_DELAY - 1))
		else $error("extended mode not using short delay");
	AST_CAL_NOT_CUT_BY_PD: assert property (
		(state_reg == ST_CAL && pd_sync) |=> state_reg == ST_CAL || state_reg == ST_IDLE)
		else $error("calibration abandoned by power-down");
	AST_IGNORE_REQ_IN_PD: assert property (
		(state_reg == ST_IDLE && pd_sync) |=> state_reg == ST_IDLE)
		else $error("calibration started while powered down");
	AST_LAUNCH_EDGE: assert property (
		data_launch |-> data_output_clock == $past(edge_sync))
		else $error("data launched on wrong clock edge");
	AST_COUNT_ON_TICK: assert property (
		(state_reg == ST_CAL && !sample_tick && state_next == ST_CAL) |=> $stable(cnt_reg))
		else $error("calibration counter moved without sample edge");
	AST_RANGE_SOURCE: assert property (
		$past(ext_mode) |-> full_scale_code == $past(fsadj_reg))
		else $error("range not taken from register in extended mode");

	COV_POWER_UP_CAL: cover property (state_reg == ST_DELAY ##1 state_reg == ST_CAL);
	COV_COMMAND_CAL: cover property (state_reg == ST_IDLE && cal_fire ##1 tune_in_progress);
	COV_SKIP_CAL: cover property (state_reg == ST_STARTUP ##1 state_reg == ST_IDLE);

endmodule
`default_nettype wire

// >>> testbench/pin_ctrl_model.sv
// far-side controller: makes the sample clock and sequences the calibrate pin
// assumes the bench pulses go for one cycle and then waits for done
`timescale 1ns/10ps
`default_nettype none
module pin_ctrl_model #(
	parameter int LOW_N = 4
) (
	// bench control
	input wire logic run,
	input wire logic go,
	input wire logic hold_hi,
	input wire logic [3:0] high_n,
	output logic done,
	// pins
	output logic sample_clk,
	output logic cal_request
);
	logic req_reg;

	// ----------------------------------------
	// pin drivers
	// ----------------------------------------
	// clock stands still low while run is low
	initial begin
		sample_clk = 1'b0;
		forever begin
			#24;
			sample_clk = run ? ~sample_clk : 1'b0;
		end
	end
	assign cal_request = hold_hi | req_reg;
	// low then high run
	// two edges of margin on the low run cover the synchroniser lag
	initial begin
		req_reg = 1'b0;
		done = 1'b1;
		forever begin
			@(posedge go);
			done = 1'b0;
			req_reg = 1'b0;
			repeat (LOW_N + 2) @(posedge sample_clk);
			req_reg = 1'b1;
			repeat (high_n) @(posedge sample_clk);
			req_reg = 1'b0;
			done = 1'b1;
		end
	end
endmodule
`default_nettype wire

// >>> testbench/tb_adc_control_pin_sequencer.sv
// bench of the calibration sequencer: pins, calibration runs and registers
// assumes pin_ctrl_model owns the sample clock and the calibrate pin
`timescale 1ns/10ps
`default_nettype none
module tb_adc_control_pin_sequencer import tune_ctrl_pkg::*;;
	logic mclk, rst_n, run, go, hold_hi, done, sample_clk, cal_request, tune_delay_select;
	logic power_down_input, launch_edge_select, driver_swing_select, input_range_select;
	logic out_of_range_in, tune_in_progress, data_output_clock, second_pair_out, data_launch;
	logic driver_strong, term_trim_active, analog_power_down, range_from_register;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
	logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic [7:0] full_scale_code, s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [3:0] high_n, s_axi_wstrb;
	logic [2:0] s_axi_awprot, s_axi_arprot;
	int fail_count, n_checks, sedges, k, t;

	// ----------------------------------------
	// instances and clocks
	// ----------------------------------------
	// short counts keep the run brief
	tune_sequencer_top #(.SHORT_DELAY(8), .LONG_DELAY(16), .CAL_RUN(8), .CAL_LOW(4),
		.CAL_HIGH(4)) DUT (
		.mclk, .rst_n, .sample_clk, .cal_request, .tune_delay_select, .power_down_input,
		.launch_edge_select, .driver_swing_select, .input_range_select, .out_of_range_in,
		.tune_in_progress, .data_output_clock, .second_pair_out, .data_launch, .driver_strong,
		.term_trim_active, .analog_power_down, .range_from_register, .full_scale_code,
		.s_axi_awaddr, .s_axi_awprot, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
		.s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arprot, .s_axi_arvalid, .s_axi_arready,
		.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
	pin_ctrl_model #(.LOW_N(4)) model (.run, .go, .hold_hi, .high_n, .done, .sample_clk,
		.cal_request);
	initial begin
		mclk = 1'b0;
		forever #2.5 mclk = ~mclk;
	end
	always @(posedge sample_clk) sedges++;
	// about three thousand cycles expected, over ten times that is a hang
	initial begin
		repeat (40000) @(posedge mclk);
		fail_count++;
		summarize();
	end

	// ----------------------------------------
	// tasks
	// ----------------------------------------
	task automatic summarize;
		$display("checks %0d mismatches %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_checks++;
		if (g !== e) begin
			fail_count++;
			$display("mismatch %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic chb(input string nm, input logic e, input logic g);
		chk(nm, {31'h0, e}, {31'h0, g});
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		@(posedge mclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge mclk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (s_axi_bvalid !== 1'b1);
		s_axi_bready <= 1'b0;
		chk("bresp", {30'h0, er}, {30'h0, s_axi_bresp});
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er,
		input string nm);
		@(posedge mclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge mclk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (s_axi_rvalid !== 1'b1);
		s_axi_rready <= 1'b0;
		chk(nm, e, s_axi_rdata);
		chk("rresp", {30'h0, er}, {30'h0, s_axi_rresp});
	endtask
	task automatic wt(input logic lvl, input int lim, input logic reach, input string nm);
		t = 0;
		while (tune_in_progress !== lvl && t < lim) begin
			@(posedge mclk);
			t++;
		end
		chb(nm, reach, t < lim);
	endtask
	task automatic togg(output int c);
		logic p;
		c = 0;
		p = data_output_clock;
		repeat (30) begin
			@(posedge mclk);
			if (data_output_clock !== p) c++;
			p = data_output_clock;
		end
	endtask
	task automatic req(input logic [3:0] hn);
		@(posedge mclk);
		high_n <= hn;
		go <= 1'b1;
		@(posedge mclk);
		go <= 1'b0;
		@(posedge mclk);
		while (done !== 1'b1) @(posedge mclk);
	endtask
	task automatic rst(input logic dsel, input logic pdi, input logic hh);
		@(posedge mclk);
		rst_n <= 1'b0;
		tune_delay_select <= dsel;
		power_down_input <= pdi;
		hold_hi <= hh;
		repeat (6) @(posedge mclk);
		rst_n <= 1'b1;
		sedges = 0;
	endtask

	// ----------------------------------------
	// tests
	// ----------------------------------------
	initial begin
		{go, hold_hi, rst_n, tune_delay_select, power_down_input, launch_edge_select} = '0;
		{driver_swing_select, input_range_select, out_of_range_in, s_axi_awvalid} = '0;
		{s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
		{s_axi_awprot, s_axi_arprot, s_axi_wstrb} = 10'h00f;
		run = 1'b1;
		high_n = 4'h6;
		rst(1'b0, 1'b0, 1'b0);
		wt(1'b1, 2000, 1'b1, "powerup start");
		chb("short delay", 1'b1, sedges >= 8 && sedges < 16);
		chb("powerup trim", 1'b1, term_trim_active);
		sedges = 0;
		togg(k);
		chk("clock frozen", 32'h0, k);
		wt(1'b0, 2000, 1'b1, "powerup end");
		chb("cal length", 1'b1, sedges >= 7 && sedges <= 9);
		rd(8'h04, 32'h0, RESP_OKAY, "trim reset");
		rd(8'h08, 32'h0, RESP_OKAY, "ctrl reset");
		rd(8'h10, 32'h80, RESP_OKAY, "fsadj reset");
		rd(8'h40, 32'h0, RESP_SLVERR, "unmapped");
		wr(8'h40, 32'h1, RESP_SLVERR);
		wr(8'h04, 32'h2000, RESP_OKAY);
		rd(8'h04, 32'h0, RESP_OKAY, "trim locked");
		wr(8'h0c, 32'hff, RESP_OKAY);
		rd(8'h0c, 32'h2a, RESP_OKAY, "status");
		for (k = 0; k < 2; k++) begin
			driver_swing_select <= k[0];
			input_range_select <= k[0];
			launch_edge_select <= k[0];
			repeat (6) @(posedge mclk);
			chb("strong", k[0], driver_strong);
			chk("fs pin", {24'h0, k[0] ? FS_CODE_HIGH : FS_CODE_LOW}, {24'h0, full_scale_code});
			t = 0;
			repeat (40) begin
				@(posedge mclk);
				if (data_launch === 1'b1) begin
					t++;
					chb("launch edge", k[0], data_output_clock);
				end
			end
			chb("launch seen", 1'b1, t > 0);
		end
		out_of_range_in <= 1'b1;
		repeat (3) @(posedge mclk);
		chb("pair oor", 1'b1, second_pair_out);
		wr(8'h08, 32'h3, RESP_OKAY);
		repeat (20) begin
			@(posedge mclk);
			chb("pair clock", data_output_clock, second_pair_out);
		end
		chb("range source", 1'b1, range_from_register);
		chk("fs reg", 32'h80, {24'h0, full_scale_code});
		wr(8'h10, 32'h5a, RESP_OKAY);
		repeat (2) @(posedge mclk);
		chk("fs written", 32'h5a, {24'h0, full_scale_code});
		s_axi_wstrb <= 4'he;
		wr(8'h10, 32'h33, RESP_OKAY);
		s_axi_wstrb <= 4'hf;
		rd(8'h10, 32'h5a, RESP_OKAY, "fs strobe");
		wr(8'h04, 32'h2000, RESP_OKAY);
		rd(8'h04, 32'h2000, RESP_OKAY, "trim inhibit");
		req(4'h2);
		repeat (20) @(posedge mclk);
		chb("glitch ignored", 1'b0, tune_in_progress);
		req(4'h6);
		chb("cal started", 1'b1, tune_in_progress);
		chb("no trim", 1'b0, term_trim_active);
		togg(k);
		chb("clock runs", 1'b1, k > 0);
		wt(1'b0, 2000, 1'b1, "cal end");
		wr(8'h04, 32'h0, RESP_OKAY);
		req(4'h6);
		chb("trim on", 1'b1, term_trim_active);
		togg(k);
		chk("clock held", 32'h0, k);
		power_down_input <= 1'b1;
		repeat (4) @(posedge mclk);
		chb("pd waits", 1'b0, analog_power_down);
		wt(1'b0, 2000, 1'b1, "cal end pd");
		repeat (4) @(posedge mclk);
		chb("pd entered", 1'b1, analog_power_down);
		req(4'h6);
		repeat (20) @(posedge mclk);
		chb("req in pd", 1'b0, tune_in_progress);
		power_down_input <= 1'b0;
		req(4'h6);
		run <= 1'b0;
		repeat (150) @(posedge mclk);
		chb("cal holds", 1'b1, tune_in_progress);
		run <= 1'b1;
		wt(1'b0, 2000, 1'b1, "cal resumes");
		run <= 1'b0;
		repeat (60) @(posedge mclk);
		chb("no clock", 1'b1, analog_power_down);
		run <= 1'b1;
		repeat (30) @(posedge mclk);
		chb("clock back", 1'b0, analog_power_down);
		rst(1'b1, 1'b0, 1'b0);
		wt(1'b1, 4000, 1'b1, "long start");
		chb("long delay", 1'b1, sedges >= 16 && sedges < 32);
		rst(1'b1, 1'b1, 1'b0);
		wt(1'b1, 400, 1'b0, "pd holds delay");
		wr(8'h08, 32'h1, RESP_OKAY);
		power_down_input <= 1'b0;
		sedges = 0;
		wt(1'b1, 2000, 1'b1, "delay after pd");
		chb("count after pd", 1'b1, sedges >= 8 && sedges < 16);
		rst(1'b0, 1'b0, 1'b1);
		wt(1'b1, 400, 1'b0, "skip powerup");
		rd(8'h0c, 32'h28, RESP_OKAY, "uncalibrated");
		hold_hi <= 1'b0;
		req(4'h6);
		chb("manual after skip", 1'b1, tune_in_progress);
		summarize();
	end
endmodule
`default_nettype wire
